// ### verilog/splm_pkg.sv
// package: register map, field positions, reset values and timing constants
// for the miscellaneous power, indicator and tagging register bank.
// assumes a 10 MHz switch clock shared by the host register port.
package splm_pkg;

    localparam logic [7:0] SPLM_ADDR_PAUSE_LIMIT = 8'hbd;
    localparam logic [7:0] SPLM_ADDR_RSVD_C0     = 8'hc0;
    localparam logic [7:0] SPLM_ADDR_REGULATOR   = 8'hc1;
    localparam logic [7:0] SPLM_ADDR_VID_INSERT  = 8'hc2;
    localparam logic [7:0] SPLM_ADDR_PWR_IND     = 8'hc3;
    localparam logic [7:0] SPLM_ADDR_SLEEP_DELAY = 8'hc4;

    localparam logic [7:0] SPLM_RST_PAUSE_LIMIT = 8'h00;
    localparam logic [7:0] SPLM_RST_RSVD_C0     = 8'h00;
    localparam logic [7:0] SPLM_RST_REGULATOR   = 8'h00;
    localparam logic [7:0] SPLM_RST_VID_INSERT  = 8'h00;
    localparam logic [7:0] SPLM_RST_PWR_IND     = 8'h00;
    localparam logic [7:0] SPLM_RST_SLEEP_DELAY = 8'h50;

    // writable bits of the mixed registers; the rest read their reset value
    localparam logic [7:0] SPLM_MASK_REGULATOR  = 8'h40;
    localparam logic [7:0] SPLM_MASK_VID_INSERT = 8'h3f;

    localparam int SPLM_BIT_REG_OFF     = 6;
    localparam int SPLM_BIT_CPU_CLK_PD  = 7;
    localparam int SPLM_BIT_SW_CLK_PD   = 6;
    localparam int SPLM_BIT_LED_MODE_HI = 5;
    localparam int SPLM_BIT_LED_MODE_LO = 4;
    localparam int SPLM_BIT_LED_DEBUG   = 3;
    localparam int SPLM_BIT_PLL_OFF     = 2;
    localparam int SPLM_BIT_PM_HI       = 1;
    localparam int SPLM_BIT_PM_LO       = 0;

    // vid insert bit per source/egress pair
    localparam int SPLM_BIT_INS_1_2 = 5;
    localparam int SPLM_BIT_INS_1_3 = 4;
    localparam int SPLM_BIT_INS_2_1 = 3;
    localparam int SPLM_BIT_INS_2_3 = 2;
    localparam int SPLM_BIT_INS_3_1 = 1;
    localparam int SPLM_BIT_INS_3_2 = 0;

    localparam longint SPLM_CLK_HZ          = 10_000_000;
    localparam longint SPLM_PAUSE_LIMIT_MS  = 160;
    localparam longint SPLM_SLEEP_UNIT_MS   = 20;
    localparam int unsigned SPLM_PAUSE_LIMIT_CYC =
        int'(SPLM_PAUSE_LIMIT_MS * SPLM_CLK_HZ / 1000);
    localparam int unsigned SPLM_SLEEP_UNIT_CYC =
        int'(SPLM_SLEEP_UNIT_MS * SPLM_CLK_HZ / 1000);

    localparam int SPLM_TIMER_W = 21;

    typedef enum logic [1:0] {
        SPLM_PM_NORMAL  = 2'h0,
        SPLM_PM_ENERGY  = 2'h1,
        SPLM_PM_SW_DOWN = 2'h2,
        SPLM_PM_SAVING  = 2'h3
    } splm_pm_mode_t;

    typedef enum logic [1:0] {
        SPLM_LED_LINKACT_SPEED = 2'h0,
        SPLM_LED_LINK_ACT      = 2'h1,
        SPLM_LED_LINKACT_DUPLX = 2'h2,
        SPLM_LED_LINK_DUPLX    = 2'h3
    } splm_led_mode_t;

    // gray along awake -> counting -> asleep
    typedef enum logic [1:0] {
        SPLM_SLP_AWAKE    = 2'h0,
        SPLM_SLP_COUNTING = 2'h1,
        SPLM_SLP_ASLEEP   = 2'h3
    } splm_sleep_st_t;

endpackage

// ### verilog/splm_cycle_timer.sv
// file: free running cycle timer that pulses once per period while enabled.
// assumes run_in comes from logic on the same clock.
`timescale 1ns/1ps
module splm_cycle_timer
    import splm_pkg::*;
#(
    parameter int unsigned PERIOD = 16
) (
    input  wire logic ref_clk_in,
    input  wire logic nrst_in,
    input  wire logic run_in,
    output logic      tick_out
);

    localparam logic [SPLM_TIMER_W-1:0] LAST =
        SPLM_TIMER_W'(PERIOD - 1);

    logic [SPLM_TIMER_W-1:0] count_q;
    logic                    tick_q;

    always_ff @(posedge ref_clk_in) begin
        if (!nrst_in || !run_in) begin
            count_q <= '0;
            tick_q  <= 1'b0;
        end else if (count_q == LAST) begin
            count_q <= '0;
            tick_q  <= 1'b1;
        end else begin
            count_q <= count_q + 1'b1;
            tick_q  <= 1'b0;
        end
    end

    assign tick_out = tick_q;

endmodule

// ### verilog/splm_regs.sv
// file: miscellaneous switch register bank (pause limit, regulator, vlan id
// insertion, clock power down, indicators, power modes, sleep entry delay).
// assumes the host register port and status inputs share ref_clk_in; only
// the analog energy signal arrives from outside and is synchronised here.
`timescale 1ns/1ps

// Overview of operation
// R01: nonzero limit requests flow control invalidation after 160 ms pause.
// R02: regulator bit 6 set disables the internal core regulator; reset zero.
// R03: six bits enable source vlan id insertion per source/egress port pair.
// R04: power bit 7 powers down the processor interface clock tree.
// R05: power bit 6 powers down the switch core clock tree.
// R06: bits 5-4 choose which link, activity, speed, duplex drive indicators.
// R07: debug bit drives inverted energy and inverted ready to indicators.
// R08: bit 2 enables pll power down.
// R09: bits 1-0 choose normal, energy detect, software down or power saving.
// R10: energy detect sleeps after no energy for delay times 20 ms.
// R11: sleep delay register resets to 0x50, giving 1.6 seconds.
// R12: writable fields read back; reserved fields keep reset value.
module splm_regs
    import splm_pkg::*;
#(
    parameter int unsigned PAUSE_LIMIT_CYC = SPLM_PAUSE_LIMIT_CYC,
    parameter int unsigned SLEEP_UNIT_CYC  = SPLM_SLEEP_UNIT_CYC
) (
    input  wire logic       ref_clk_in,
    input  wire logic       nrst_in,
    input  wire logic [7:0] reg_addr_in,
    input  wire logic       reg_wr_in,
    input  wire logic       reg_rd_in,
    input  wire logic [7:0] reg_wdata_in,
    output logic      [7:0] reg_rdata_out,
    input  wire logic       pause_active_in,
    output logic            fc_invalidate_req_out,
    output logic            regulator_off_out,
    input  wire logic       frame_valid_in,
    input  wire logic       frame_untagged_in,
    input  wire logic [1:0] frame_src_port_in,
    input  wire logic [1:0] frame_egress_port_in,
    output logic            insert_src_vid_out,
    output logic            cpu_clk_pd_out,
    output logic            sw_clk_pd_out,
    input  wire logic       link_in,
    input  wire logic       act_in,
    input  wire logic       speed_in,
    input  wire logic       duplex_in,
    input  wire logic       energy_in,
    input  wire logic       device_ready_in,
    output logic            first_indicator_output_n_out,
    output logic            second_indicator_output_n_out,
    output logic            pll_pd_en_out,
    output logic      [1:0] pm_mode_out,
    output logic            low_power_out
);

    ////////////////////////////////////////////////////////////////////////
    // register storage

    logic [7:0]     pause_limit_q;
    logic [7:0]     regulator_q;
    logic [7:0]     vid_insert_q;
    logic [7:0]     pwr_ind_q;
    logic [7:0]     sleep_delay_q;
    logic [7:0]     rdata_q;
    logic [7:0]     rdata_d;

    always_ff @(posedge ref_clk_in) begin
        if (!nrst_in) begin
            pause_limit_q <= SPLM_RST_PAUSE_LIMIT;
            regulator_q   <= SPLM_RST_REGULATOR;
            vid_insert_q  <= SPLM_RST_VID_INSERT;
            pwr_ind_q     <= SPLM_RST_PWR_IND;
            sleep_delay_q <= SPLM_RST_SLEEP_DELAY; // R11
        end else if (reg_wr_in) begin
            case (reg_addr_in)
                SPLM_ADDR_PAUSE_LIMIT: pause_limit_q <= reg_wdata_in;
                SPLM_ADDR_REGULATOR: begin
                    regulator_q <= (reg_wdata_in & SPLM_MASK_REGULATOR) |
                        (SPLM_RST_REGULATOR & ~SPLM_MASK_REGULATOR); // R12
                end
                SPLM_ADDR_VID_INSERT: begin
                    vid_insert_q <= (reg_wdata_in & SPLM_MASK_VID_INSERT) |
                        (SPLM_RST_VID_INSERT & ~SPLM_MASK_VID_INSERT); // R12
                end
                SPLM_ADDR_PWR_IND:     pwr_ind_q     <= reg_wdata_in;
                SPLM_ADDR_SLEEP_DELAY: sleep_delay_q <= reg_wdata_in;
                default: begin
                end
            endcase
        end
    end

    always_comb begin
        case (reg_addr_in)
            SPLM_ADDR_PAUSE_LIMIT: rdata_d = pause_limit_q;
            SPLM_ADDR_RSVD_C0:     rdata_d = SPLM_RST_RSVD_C0; // R12
            SPLM_ADDR_REGULATOR:   rdata_d = regulator_q;
            SPLM_ADDR_VID_INSERT:  rdata_d = vid_insert_q;
            SPLM_ADDR_PWR_IND:     rdata_d = pwr_ind_q;
            SPLM_ADDR_SLEEP_DELAY: rdata_d = sleep_delay_q;
            default:               rdata_d = 8'h00;
        endcase
    end

    // read data holds until the next read strobe
    always_ff @(posedge ref_clk_in) begin
        if (!nrst_in) begin
            rdata_q <= 8'h00;
        end else if (reg_rd_in) begin
            rdata_q <= rdata_d; // R12
        end
    end

    assign reg_rdata_out     = rdata_q;
    assign regulator_off_out = regulator_q[SPLM_BIT_REG_OFF]; // R02
    assign cpu_clk_pd_out    = pwr_ind_q[SPLM_BIT_CPU_CLK_PD]; // R04
    assign sw_clk_pd_out     = pwr_ind_q[SPLM_BIT_SW_CLK_PD]; // R05
    assign pll_pd_en_out     = pwr_ind_q[SPLM_BIT_PLL_OFF]; // R08
    assign pm_mode_out       =
        pwr_ind_q[SPLM_BIT_PM_HI:SPLM_BIT_PM_LO]; // R09

    ////////////////////////////////////////////////////////////////////////
    // flow control pause limit

    logic pause_tick;
    logic fc_req_q;

    splm_cycle_timer #(
        .PERIOD (PAUSE_LIMIT_CYC)
    ) u_pause_timer (
        .ref_clk_in (ref_clk_in),
        .nrst_in    (nrst_in),
        .run_in     (pause_active_in && (pause_limit_q != 8'h00)), // R01
        .tick_out   (pause_tick)
    );

    always_ff @(posedge ref_clk_in) begin
        if (!nrst_in) begin
            fc_req_q <= 1'b0;
        end else begin
            fc_req_q <= pause_tick && pause_active_in &&
                        (pause_limit_q != 8'h00); // R01
        end
    end

    assign fc_invalidate_req_out = fc_req_q;

    ////////////////////////////////////////////////////////////////////////
    // source vlan id insertion decision

    logic insert_q;
    logic pair_en;

    always_comb begin
        case ({frame_src_port_in, frame_egress_port_in})
            4'h6:    pair_en = vid_insert_q[SPLM_BIT_INS_1_2];
            4'h7:    pair_en = vid_insert_q[SPLM_BIT_INS_1_3];
            4'h9:    pair_en = vid_insert_q[SPLM_BIT_INS_2_1];
            4'hb:    pair_en = vid_insert_q[SPLM_BIT_INS_2_3];
            4'hd:    pair_en = vid_insert_q[SPLM_BIT_INS_3_1];
            4'he:    pair_en = vid_insert_q[SPLM_BIT_INS_3_2];
            default: pair_en = 1'b0;
        endcase
    end

    always_ff @(posedge ref_clk_in) begin
        if (!nrst_in) begin
            insert_q <= 1'b0;
        end else begin
            insert_q <= frame_valid_in && frame_untagged_in && pair_en; // R03
        end
    end

    assign insert_src_vid_out = insert_q;

    ////////////////////////////////////////////////////////////////////////
    // energy input synchroniser and indicators

    logic           energy_meta_q;
    logic           energy_s_q;
    logic           first_n_q;
    logic           second_n_q;
    logic           link_act;
    splm_led_mode_t led_mode;

    always_ff @(posedge ref_clk_in) begin
        if (!nrst_in) begin
            energy_meta_q <= 1'b0;
            energy_s_q    <= 1'b0;
        end else begin
            energy_meta_q <= energy_in;
            energy_s_q    <= energy_meta_q;
        end
    end

    // combined link/activity: lit on link, blinks off with traffic
    assign link_act = link_in && !act_in;
    assign led_mode = splm_led_mode_t'(
        pwr_ind_q[SPLM_BIT_LED_MODE_HI:SPLM_BIT_LED_MODE_LO]);

    // pins are active low
    always_ff @(posedge ref_clk_in) begin
        if (!nrst_in) begin
            first_n_q  <= 1'b1;
            second_n_q <= 1'b1;
        end else if (pwr_ind_q[SPLM_BIT_LED_DEBUG]) begin
            first_n_q  <= !device_ready_in; // R07
            second_n_q <= !energy_s_q; // R07
        end else begin
            case (led_mode)
                SPLM_LED_LINKACT_SPEED: begin
                    first_n_q  <= !link_act; // R06
                    second_n_q <= !speed_in;
                end
                SPLM_LED_LINK_ACT: begin
                    first_n_q  <= !link_in; // R06
                    second_n_q <= !act_in;
                end
                SPLM_LED_LINKACT_DUPLX: begin
                    first_n_q  <= !link_act; // R06
                    second_n_q <= !duplex_in;
                end
                default: begin
                    first_n_q  <= !link_in; // R06
                    second_n_q <= !duplex_in;
                end
            endcase
        end
    end

    assign first_indicator_output_n_out  = first_n_q;
    assign second_indicator_output_n_out = second_n_q;

    ////////////////////////////////////////////////////////////////////////
    // energy detect sleep entry

    splm_sleep_st_t slp_q;
    logic [7:0]     units_q;
    logic           unit_tick;
    logic           low_power_q;
    logic           energy_detect_mode;

    assign energy_detect_mode = (pm_mode_out == SPLM_PM_ENERGY);

    splm_cycle_timer #(
        .PERIOD (SLEEP_UNIT_CYC)
    ) u_unit_timer (
        .ref_clk_in (ref_clk_in),
        .nrst_in    (nrst_in),
        .run_in     (slp_q == SPLM_SLP_COUNTING && !energy_s_q),
        .tick_out   (unit_tick)
    );

    always_ff @(posedge ref_clk_in) begin
        if (!nrst_in) begin
            slp_q   <= SPLM_SLP_AWAKE;
            units_q <= 8'h00;
        end else if (!energy_detect_mode || energy_s_q) begin
            slp_q   <= SPLM_SLP_AWAKE;
            units_q <= 8'h00;
        end else begin
            case (slp_q)
                SPLM_SLP_AWAKE: begin
                    slp_q   <= SPLM_SLP_COUNTING;
                    units_q <= 8'h00;
                end
                SPLM_SLP_COUNTING: begin
                    if (units_q >= sleep_delay_q) begin
                        slp_q <= SPLM_SLP_ASLEEP; // R10
                    end else if (unit_tick) begin
                        units_q <= units_q + 8'h01; // R10
                    end
                end
                SPLM_SLP_ASLEEP: begin
                    slp_q <= SPLM_SLP_ASLEEP;
                end
                default: begin
                    slp_q <= SPLM_SLP_AWAKE;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!nrst_in) begin
            low_power_q <= 1'b0;
        end else begin
            low_power_q <= (slp_q == SPLM_SLP_ASLEEP) && energy_detect_mode &&
                           !energy_s_q; // R10
        end
    end

    assign low_power_out = low_power_q;

    ////////////////////////////////////////////////////////////////////////
    // checks

    pause_req_a: assert property (@(posedge ref_clk_in) // R01
        disable iff (!nrst_in)
        fc_invalidate_req_out |-> $past(pause_limit_q) != 8'h00 &&
            $past(pause_active_in, 2))
        else $error("flow control request without pause limit");

    reg_off_a: assert property (@(posedge ref_clk_in) // R02
        disable iff (!nrst_in)
        reg_wr_in && reg_addr_in == SPLM_ADDR_REGULATOR |=>
            regulator_off_out == $past(reg_wdata_in[SPLM_BIT_REG_OFF]))
        else $error("regulator disable not taken from write");

    tag_insert_a: assert property (@(posedge ref_clk_in) // R03
        disable iff (!nrst_in)
        frame_valid_in && frame_untagged_in && frame_src_port_in == 2'h3 &&
            frame_egress_port_in == 2'h1 |=>
            insert_src_vid_out == $past(vid_insert_q[SPLM_BIT_INS_3_1]))
        else $error("port 3 to 1 insertion wrong");

    cpu_pd_a: assert property (@(posedge ref_clk_in) // R04
        disable iff (!nrst_in)
        reg_wr_in && reg_addr_in == SPLM_ADDR_PWR_IND |=>
            cpu_clk_pd_out == $past(reg_wdata_in[SPLM_BIT_CPU_CLK_PD]))
        else $error("cpu clock power down not taken");

    sw_pd_a: assert property (@(posedge ref_clk_in) // R05
        disable iff (!nrst_in)
        reg_wr_in && reg_addr_in == SPLM_ADDR_PWR_IND |=>
            sw_clk_pd_out == $past(reg_wdata_in[SPLM_BIT_SW_CLK_PD]))
        else $error("switch clock power down not taken");

    led_mode_a: assert property (@(posedge ref_clk_in) // R06
        disable iff (!nrst_in)
        !pwr_ind_q[SPLM_BIT_LED_DEBUG] && led_mode == SPLM_LED_LINK_ACT |=>
            first_indicator_output_n_out == !$past(link_in) &&
            second_indicator_output_n_out == !$past(act_in))
        else $error("link and activity indicators wrong");

    led_debug_a: assert property (@(posedge ref_clk_in) // R07
        disable iff (!nrst_in)
        pwr_ind_q[SPLM_BIT_LED_DEBUG] |=>
            second_indicator_output_n_out == !$past(energy_s_q) &&
            first_indicator_output_n_out == !$past(device_ready_in))
        else $error("debug indicator output wrong");

    pll_pd_a: assert property (@(posedge ref_clk_in) // R08
        disable iff (!nrst_in)
        reg_wr_in && reg_addr_in == SPLM_ADDR_PWR_IND |=>
            pll_pd_en_out == $past(reg_wdata_in[SPLM_BIT_PLL_OFF]))
        else $error("pll power down enable not taken");

    pm_mode_a: assert property (@(posedge ref_clk_in) // R09
        disable iff (!nrst_in)
        !reg_wr_in |=> $stable(pm_mode_out))
        else $error("power mode changed without a write");

    sleep_entry_a: assert property (@(posedge ref_clk_in) // R10
        disable iff (!nrst_in)
        $rose(low_power_out) |-> $past(energy_detect_mode) &&
            $past(units_q, 2) >= $past(sleep_delay_q, 2) &&
            !$past(energy_s_q))
        else $error("low power entered before sleep delay");

    sleep_reset_a: assert property (@(posedge ref_clk_in) // R11
        !nrst_in |=> sleep_delay_q == SPLM_RST_SLEEP_DELAY)
        else $error("sleep delay reset value wrong");

    rsvd_read_a: assert property (@(posedge ref_clk_in) // R12
        disable iff (!nrst_in)
        reg_rd_in && reg_addr_in == SPLM_ADDR_RSVD_C0 |=>
            reg_rdata_out == SPLM_RST_RSVD_C0)
        else $error("reserved register read not zero");

    fc_req_c: cover property (@(posedge ref_clk_in)
        disable iff (!nrst_in) fc_invalidate_req_out);

    sleep_c: cover property (@(posedge ref_clk_in)
        disable iff (!nrst_in) $rose(low_power_out));

    insert_c: cover property (@(posedge ref_clk_in)
        disable iff (!nrst_in) insert_src_vid_out);

    debug_c: cover property (@(posedge ref_clk_in)
        disable iff (!nrst_in) pwr_ind_q[SPLM_BIT_LED_DEBUG]);

endmodule

// ### tb/switch_power_led_misc_regs_bench.sv
// testbench: drives the misc register bank through its strobe port and
// checks registers, control outputs, indicators, pause and sleep timing.
// assumes one 10 MHz clock and shortened pause and sleep timer periods.
`timescale 1ns/1ps
module switch_power_led_misc_regs_bench;
    import splm_pkg::*;

    localparam int unsigned PCYC = 20;
    localparam int unsigned SCYC = 10;

    logic       clk    = 1'b0;
    logic       nrst   = 1'b0;
    logic [7:0] addr   = 8'h00;
    logic [7:0] wdata  = 8'h00;
    logic       wr     = 1'b0;
    logic       rd     = 1'b0;
    logic       pause  = 1'b0;
    logic       fvalid = 1'b0;
    logic       funtag = 1'b0;
    logic [1:0] fsrc   = 2'h0;
    logic [1:0] fegr   = 2'h0;
    logic       link   = 1'b1;
    logic       act    = 1'b1;
    logic       speed  = 1'b1;
    logic       duplex = 1'b0;
    logic       energy = 1'b0;
    logic       ready  = 1'b1;
    logic [7:0] rdata;
    logic [1:0] pm;
    logic       fc_req, reg_off, ins, cpu_pd, sw_pd;
    logic       first_indicator_output_n, second_indicator_output_n, pll_pd, low_pwr;
    int         fails  = 0;
    int         checks = 0;
    int         n;

    logic [7:0] adr [6] = '{8'hbd, 8'hc0, 8'hc1, 8'hc2, 8'hc3, 8'hc4};
    logic [7:0] rstv[6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h50};
    logic [7:0] onev[6] = '{8'hff, 8'h00, 8'h40, 8'h3f, 8'hff, 8'hff};
    logic [7:0] pwv [7] = '{8'h80, 8'h40, 8'h04, 8'h00, 8'h01, 8'h02, 8'h03};
    logic [1:0] psrc[6] = '{2'h1, 2'h1, 2'h2, 2'h2, 2'h3, 2'h3};
    logic [1:0] pegr[6] = '{2'h2, 2'h3, 2'h1, 2'h3, 2'h1, 2'h2};
    logic [1:0] ledx[4] = '{2'b10, 2'b00, 2'b11, 2'b01};

    always #50 clk = ~clk;

    splm_regs #(
        .PAUSE_LIMIT_CYC(PCYC),
        .SLEEP_UNIT_CYC (SCYC)
    ) dut_u (
        .ref_clk_in                   (clk),
        .nrst_in                      (nrst),
        .reg_addr_in                  (addr),
        .reg_wr_in                    (wr),
        .reg_rd_in                    (rd),
        .reg_wdata_in                 (wdata),
        .reg_rdata_out                (rdata),
        .pause_active_in              (pause),
        .fc_invalidate_req_out        (fc_req),
        .regulator_off_out            (reg_off),
        .frame_valid_in               (fvalid),
        .frame_untagged_in            (funtag),
        .frame_src_port_in            (fsrc),
        .frame_egress_port_in         (fegr),
        .insert_src_vid_out           (ins),
        .cpu_clk_pd_out               (cpu_pd),
        .sw_clk_pd_out                (sw_pd),
        .link_in                      (link),
        .act_in                       (act),
        .speed_in                     (speed),
        .duplex_in                    (duplex),
        .energy_in                    (energy),
        .device_ready_in              (ready),
        .first_indicator_output_n_out (first_indicator_output_n),
        .second_indicator_output_n_out(second_indicator_output_n),
        .pll_pd_en_out                (pll_pd),
        .pm_mode_out                  (pm),
        .low_power_out                (low_pwr)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    task automatic close_out();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic cycles(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) #1;
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(posedge clk) #1;
        wr = 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk) #1;
        addr = a;
        rd = 1'b1;
        @(posedge clk) #1;
        rd = 1'b0;
        check(rdata, exp);
    endtask

    // one frame decision; insertion answer is settled after the next edge
    task automatic frame(input logic [1:0] s, input logic [1:0] e,
                         input logic u);
        @(posedge clk) #1;
        fsrc = s;
        fegr = e;
        funtag = u;
        fvalid = 1'b1;
        @(posedge clk) #1;
        fvalid = 1'b0;
    endtask

    // bounded wait on the pause request (sel 0) or low power (sel 1)
    task automatic wait_hi(input bit sel, input int lim, output int c);
        c = 0;
        while ((sel ? low_pwr : fc_req) !== 1'b1) begin
            if (c == lim) begin
                fails++;
                $display("timeout at %0t", $time);
                close_out();
            end
            @(posedge clk) #1;
            c++;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge clk);
        #1;
        nrst = 1'b1;
        for (int i = 0; i < 6; i++) rd_chk(adr[i], rstv[i]);
        rd_chk(8'h10, 8'h00);
        check({4'h0, reg_off, cpu_pd, sw_pd, pll_pd}, 8'h00);
        check({4'h0, pm, low_pwr, fc_req}, 8'h00);
        $display("test reset done");

        for (int i = 0; i < 6; i++) wr_reg(adr[i], 8'hff);
        for (int i = 0; i < 6; i++) rd_chk(adr[i], onev[i]);
        check({7'h0, reg_off}, 8'h01);
        wr_reg(8'hc1, 8'hbf);
        check({7'h0, reg_off}, 8'h00);
        rd_chk(8'hc1, 8'h00);
        for (int i = 0; i < 7; i++) begin
            wr_reg(8'hc3, pwv[i]);
            check({7'h0, cpu_pd}, {7'h0, pwv[i][7]});
            check({7'h0, sw_pd}, {7'h0, pwv[i][6]});
            check({7'h0, pll_pd}, {7'h0, pwv[i][2]});
            check({6'h0, pm}, {6'h0, pwv[i][1:0]});
        end
        $display("test access done");

        for (int k = 0; k < 6; k++) begin
            wr_reg(8'hc2, 8'h20 >> k);
            for (int j = 0; j < 6; j++) begin
                frame(psrc[j], pegr[j], 1'b1);
                check({7'h0, ins}, {7'h0, j == k});
            end
        end
        wr_reg(8'hc2, 8'h3f);
        frame(2'h1, 2'h2, 1'b0);
        check({7'h0, ins}, 8'h00);
        $display("test insert done");

        for (int m = 0; m < 4; m++) begin
            wr_reg(8'hc3, 8'(m << 4));
            cycles(2);
            check({6'h0, first_indicator_output_n, second_indicator_output_n}, {6'h0, ledx[m]});
        end
        wr_reg(8'hc3, 8'h08);
        cycles(4);
        check({6'h0, first_indicator_output_n, second_indicator_output_n}, 8'h01);
        energy = 1'b1;
        ready = 1'b0;
        cycles(4);
        check({6'h0, first_indicator_output_n, second_indicator_output_n}, 8'h02);
        $display("test indicator done");

        wr_reg(8'hbd, 8'h01);
        pause = 1'b1;
        wait_hi(1'b0, 60, n);
        check(8'(n >= PCYC && n <= PCYC + 3), 8'h01);
        pause = 1'b0;
        wr_reg(8'hbd, 8'h00);
        pause = 1'b1;
        n = 0;
        repeat (3 * PCYC) begin
            cycles(1);
            n += int'(fc_req === 1'b1);
        end
        check(8'(n), 8'h00);
        pause = 1'b0;
        $display("test pause done");

        energy = 1'b0;
        wr_reg(8'hc4, 8'h02);
        wr_reg(8'hc3, 8'h01);
        wait_hi(1'b1, 100, n);
        check(8'(n >= 2 * SCYC && n <= 2 * SCYC + 10), 8'h01);
        energy = 1'b1;
        cycles(5);
        check({7'h0, low_pwr}, 8'h00);
        $display("test sleep done");
        close_out();
    end

endmodule
